// *** rtl/twop_ctrl.sv ***
// two-wire byte controller with software operation handshake
//
// Design decisions made here: the address map and register access over Wishbone.
`timescale 1ns/1ps
`include "twop_params.svh"

module twop_ctrl (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  // wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [`TWOP_ADR_W-1:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // two-wire pins, open drain
  input wire logic i_scl,
  output logic o_scl_o,
  output logic o_scl_oe,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe,
  // status outputs
  output twop_pkg::twop_mode_e o_bus_mode,
  output logic o_irq
);
  import twop_pkg::*;

  // ==========================================================
  // state
  twop_state_e state_r;
  twop_mode_e mode_r;
  logic [7:0] ctrl_r, shreg_r, code_r, status_r;
  logic [`TWOP_IRQ_W-1:0] irq_st_r, irq_mask_r;
  logic [`TWOP_QCNT_W-1:0] qcnt_r;
  logic [1:0] q_r;
  logic [3:0] cnt_r;
  logic tick_r, flag_r, done_r, go_r, wc_r, first_r, ackd_r, stop_evt_r, wc_evt_r;
  logic scl_drv_r, sda_drv_r, zero_r, ack_r, irq_r;
  logic [31:0] rdat_r;
  logic scl_m_r, scl_s_r, scl_p_r, sda_m_r, sda_s_r, sda_p_r;

  // code of a completed byte, shared by master and slave paths
  function automatic logic [7:0] code_of(input logic slave, input logic first, input logic rd, input logic ackd);
    logic [7:0] c;
    c = `TWOP_SC_NONE;
    if (!slave && first) c = rd ? (ackd ? `TWOP_SC_MR_ACK : `TWOP_SC_MR_NACK)
                                : (ackd ? `TWOP_SC_MW_ACK : `TWOP_SC_MW_NACK);
    else if (!slave) c = rd ? (ackd ? `TWOP_SC_MRD_ACK : `TWOP_SC_MRD_NACK)
                            : (ackd ? `TWOP_SC_MTD_ACK : `TWOP_SC_MTD_NACK);
    else if (first) c = rd ? `TWOP_SC_SR_ADDR : `TWOP_SC_SW_ADDR;
    else c = rd ? (ackd ? `TWOP_SC_STD_ACK : `TWOP_SC_STD_NACK)
                : (ackd ? `TWOP_SC_SRD_ACK : `TWOP_SC_SRD_NACK);
    return c;
  endfunction

  // ==========================================================
  // bus decode
  wire wb_hit_w = i_wb_cyc & i_wb_stb & ~ack_r;
  wire wb_wr_w = wb_hit_w & i_wb_we & i_wb_sel[0];
  wire sel_ctrl_w = i_wb_adr == `TWOP_OFS_CTRL;
  wire sel_stat_w = i_wb_adr == `TWOP_OFS_STATUS;
  wire sel_data_w = i_wb_adr == `TWOP_OFS_DATA;
  wire sel_ist_w = i_wb_adr == `TWOP_OFS_IRQ_ST;
  wire sel_imask_w = i_wb_adr == `TWOP_OFS_IRQ_MASK;
  wire ctrl_wr_w = wb_wr_w & sel_ctrl_w;
  wire clr_w = ctrl_wr_w & i_wb_dat[`TWOP_CTRL_FLAG];
  wire data_wr_w = wb_wr_w & sel_data_w;
  wire [31:0] ctrl_rd_w = {21'h00000, mode_r, flag_r, ctrl_r[6:4], wc_r, ctrl_r[2:0]};
  wire [31:0] rd_mux_w = sel_ctrl_w ? ctrl_rd_w :
                         sel_stat_w ? {24'h000000, status_r} :
                         sel_data_w ? {24'h000000, shreg_r} :
                         sel_ist_w ? {29'h0000000, irq_st_r} :
                         sel_imask_w ? {29'h0000000, irq_mask_r} : 32'h00000000;

  // ==========================================================
  // line sampling; the second and third stages feed logic, never the first
  wire scl_rise_w = scl_s_r & ~scl_p_r;
  wire scl_fall_w = ~scl_s_r & scl_p_r;
  wire bus_start_w = scl_s_r & scl_p_r & sda_p_r & ~sda_s_r;
  wire bus_stop_w = scl_s_r & scl_p_r & ~sda_p_r & sda_s_r;
  // master phase advance; waits at quarter 2 while someone stretches the clock
  wire adv_w = tick_r & ~(q_r == 2'h2 & ~scl_s_r);
  wire byte_end_w = cnt_r == `TWOP_BYTE_BITS;
  wire is_slave_w = mode_r == MODE_STX || mode_r == MODE_SRX;
  wire m_rd_data_w = mode_r == MODE_MRX && !first_r;
  wire launch_w = state_r == SM_HOLD && !flag_r && !done_r && go_r;
  wire [`TWOP_IRQ_W-1:0] irq_evt_w = {wc_evt_r, stop_evt_r, done_r};

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      {scl_m_r, scl_s_r, scl_p_r, sda_m_r, sda_s_r, sda_p_r} <= 6'h3F;
    end else begin
      {scl_m_r, scl_s_r, scl_p_r} <= {i_scl, scl_m_r, scl_s_r};
      {sda_m_r, sda_s_r, sda_p_r} <= {i_sda, sda_m_r, sda_s_r};
    end
  end

  // quarter-bit enable; free running keeps the divider trivial
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      qcnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= qcnt_r == `TWOP_QCNT_W'(`TWOP_QTR_CYC - 1);
      qcnt_r <= (qcnt_r == `TWOP_QCNT_W'(`TWOP_QTR_CYC - 1)) ? '0 : qcnt_r + 1'b1;
    end
  end

  // ==========================================================
  // register bus: one wait state, ack drops after one cycle
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ack_r <= 1'b0;
      rdat_r <= '0;
      ctrl_r <= `TWOP_CTRL_RST;
      irq_mask_r <= '0;
    end else begin
      ack_r <= wb_hit_w;
      if (wb_hit_w) rdat_r <= rd_mux_w;
      if (ctrl_wr_w) ctrl_r <= i_wb_dat[7:0];
      if (wb_wr_w && sel_imask_w) irq_mask_r <= i_wb_dat[`TWOP_IRQ_W-1:0];
    end
  end

  // done flag: a new completion wins over a clearing write
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      flag_r <= 1'b0;
      status_r <= `TWOP_SC_NONE;
    end else begin
      flag_r <= done_r | (flag_r & ~clr_w);
      status_r <= flag_r ? code_r : `TWOP_SC_NONE;
    end
  end

  // sticky interrupt bits, write one to clear, events win
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      irq_st_r <= '0;
      irq_r <= 1'b0;
    end else begin
      irq_st_r <= irq_evt_w | (irq_st_r & ~((wb_wr_w && sel_ist_w) ? i_wb_dat[`TWOP_IRQ_W-1:0] : '0));
      irq_r <= |(irq_st_r & irq_mask_r);
    end
  end

  // ==========================================================
  // byte engine: master by quarter ticks, slave by clock edges
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_r <= SM_IDLE;
      mode_r <= MODE_NONE;
      shreg_r <= '0;
      code_r <= `TWOP_SC_NONE;
      q_r <= '0;
      cnt_r <= '0;
      {done_r, go_r, wc_r, first_r, ackd_r, stop_evt_r, wc_evt_r} <= '0;
      {scl_drv_r, sda_drv_r, zero_r} <= '0;
    end else begin
      done_r <= 1'b0;
      stop_evt_r <= 1'b0;
      wc_evt_r <= 1'b0;
      zero_r <= 1'b0;
      if (clr_w) go_r <= 1'b1;
      if (ctrl_wr_w) wc_r <= 1'b0;
      // data writes outside a pause would corrupt the shifter
      if (data_wr_w && (flag_r || state_r == SM_IDLE)) shreg_r <= i_wb_dat[7:0];
      else if (data_wr_w) {wc_r, wc_evt_r} <= 2'h3;
      if (adv_w) q_r <= q_r + 1'b1;
      unique case (state_r)
        SM_IDLE: begin
          mode_r <= MODE_NONE;
          if (go_r && ctrl_r[`TWOP_CTRL_EN] && ctrl_r[`TWOP_CTRL_START]) begin
            go_r <= 1'b0;
            q_r <= '0;
            state_r <= SM_M_START;
          end else if (ctrl_r[`TWOP_CTRL_EN] && ctrl_r[`TWOP_CTRL_ACKEN] && bus_start_w) begin
            cnt_r <= '0;
            first_r <= 1'b1;
            state_r <= SM_S_RX;
          end
        end
        SM_M_START: if (adv_w) begin
          if (q_r == 2'h0) sda_drv_r <= 1'b0;
          if (q_r == 2'h1) scl_drv_r <= 1'b0;
          if (q_r == 2'h2) sda_drv_r <= 1'b1;
          if (q_r == 2'h3) begin
            scl_drv_r <= 1'b1;
            code_r <= (mode_r == MODE_NONE) ? `TWOP_SC_START : `TWOP_SC_RSTART;
            mode_r <= MODE_MTX;
            done_r <= 1'b1;
            first_r <= 1'b1;
            state_r <= SM_HOLD;
          end
        end
        SM_M_BIT: if (adv_w) begin
          if (q_r == 2'h0) sda_drv_r <= m_rd_data_w ? 1'b0 : ~shreg_r[7];
          if (q_r == 2'h1) scl_drv_r <= 1'b0;
          if (q_r == 2'h3) begin
            scl_drv_r <= 1'b1;
            shreg_r <= {shreg_r[6:0], sda_s_r};
            cnt_r <= cnt_r + 1'b1;
            if (cnt_r == `TWOP_BYTE_BITS - 4'h1) state_r <= SM_M_ACK;
          end
        end
        SM_M_ACK: if (adv_w) begin
          // receiver acks by pulling data low, nack leaves it high
          if (q_r == 2'h0) sda_drv_r <= m_rd_data_w & ctrl_r[`TWOP_CTRL_ACKEN];
          if (q_r == 2'h1) scl_drv_r <= 1'b0;
          if (q_r == 2'h3) begin
            scl_drv_r <= 1'b1;
            code_r <= code_of(1'b0, first_r, first_r ? shreg_r[0] : mode_r == MODE_MRX, ~sda_s_r);
            if (first_r) mode_r <= shreg_r[0] ? MODE_MRX : MODE_MTX;
            done_r <= 1'b1;
            state_r <= SM_HOLD;
          end
        end
        SM_M_STOP: if (adv_w) begin
          if (q_r == 2'h0) sda_drv_r <= 1'b1;
          if (q_r == 2'h1) scl_drv_r <= 1'b0;
          if (q_r == 2'h3) begin
            sda_drv_r <= 1'b0;
            stop_evt_r <= 1'b1;
            mode_r <= MODE_NONE;
            q_r <= '0;
            state_r <= ctrl_r[`TWOP_CTRL_START] ? SM_M_START : SM_IDLE;
          end
        end
        SM_HOLD: begin
          scl_drv_r <= 1'b1;
          if (launch_w) begin
            go_r <= 1'b0;
            q_r <= '0;
            cnt_r <= '0;
            if (is_slave_w) begin
              scl_drv_r <= 1'b0;
              first_r <= 1'b0;
              sda_drv_r <= (mode_r == MODE_STX) & ~shreg_r[7];
              state_r <= (mode_r == MODE_STX) ? SM_S_TX : SM_S_RX;
            end else if (ctrl_r[`TWOP_CTRL_STOP]) state_r <= SM_M_STOP;
            else if (ctrl_r[`TWOP_CTRL_START]) state_r <= SM_M_START;
            else state_r <= SM_M_BIT;
            if (!is_slave_w && !ctrl_r[`TWOP_CTRL_STOP] && !ctrl_r[`TWOP_CTRL_START] && !first_r) first_r <= 1'b0;
          end
        end
        SM_S_RX: begin
          if (scl_rise_w) begin
            shreg_r <= {shreg_r[6:0], sda_s_r};
            cnt_r <= cnt_r + 1'b1;
          end
          if (scl_fall_w && byte_end_w) begin
            sda_drv_r <= ctrl_r[`TWOP_CTRL_ACKEN];
            state_r <= SM_S_RACK;
          end
          if (bus_stop_w) state_r <= SM_IDLE;
        end
        SM_S_RACK: if (scl_fall_w) begin
          sda_drv_r <= 1'b0;
          scl_drv_r <= 1'b1;
          code_r <= code_of(1'b1, first_r, first_r & shreg_r[0], ctrl_r[`TWOP_CTRL_ACKEN]);
          if (first_r) mode_r <= shreg_r[0] ? MODE_STX : MODE_SRX;
          done_r <= 1'b1;
          state_r <= SM_HOLD;
        end
        SM_S_TX: begin
          if (scl_rise_w) begin
            shreg_r <= {shreg_r[6:0], sda_s_r};
            cnt_r <= cnt_r + 1'b1;
          end
          if (scl_fall_w) sda_drv_r <= ~byte_end_w & ~shreg_r[7];
          if (scl_fall_w && byte_end_w) state_r <= SM_S_TACK;
          // a stop cut into our byte must not leave data pulled low
          if (bus_stop_w) begin
            sda_drv_r <= 1'b0;
            state_r <= SM_IDLE;
          end
        end
        SM_S_TACK: begin
          if (scl_rise_w) ackd_r <= ~sda_s_r;
          if (scl_fall_w) begin
            scl_drv_r <= 1'b1;
            code_r <= code_of(1'b1, 1'b0, 1'b1, ackd_r);
            done_r <= 1'b1;
            state_r <= SM_HOLD;
          end
        end
      endcase
      if (state_r == SM_M_ACK && adv_w && q_r == 2'h3) first_r <= 1'b0;
    end
  end

  // ==========================================================
  // outputs, all registered
  assign o_wb_dat = rdat_r;
  assign o_wb_ack = ack_r;
  assign o_scl_o = zero_r;
  assign o_sda_o = zero_r;
  assign o_scl_oe = scl_drv_r;
  assign o_sda_oe = sda_drv_r;
  assign o_bus_mode = mode_r;
  assign o_irq = irq_r;

  // ==========================================================
  // checks
  a_done_sets_flag: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    done_r |=> flag_r) else $error("completion did not raise the flag");
  a_flag_holds_clock: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    flag_r |-> scl_drv_r && o_scl_oe) else $error("clock released while flag set");
  a_write_one_clears: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (flag_r && clr_w && !done_r) |=> !flag_r) else $error("flag not cleared by writing one");
  a_launch_after_clear: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    launch_w |=> state_r != SM_HOLD) else $error("operation did not begin after clear");
  a_start_done_code: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (state_r == SM_M_START && adv_w && q_r == 2'h3) |=> done_r ##1 flag_r ##1
    (status_r == `TWOP_SC_START || status_r == `TWOP_SC_RSTART)) else $error("start not reported");
  a_addr_write_done: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (state_r == SM_M_ACK && adv_w && q_r == 2'h3 && first_r && !shreg_r[0]) |=>
    done_r && (code_r == `TWOP_SC_MW_ACK || code_r == `TWOP_SC_MW_NACK)) else $error("address write not reported");
  a_data_tx_done: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (state_r == SM_M_ACK && adv_w && q_r == 2'h3 && !first_r && mode_r == MODE_MTX) |=>
    done_r && code_r == (sda_drv_r ? `TWOP_SC_MTD_ACK : $past(sda_s_r) ? `TWOP_SC_MTD_NACK : `TWOP_SC_MTD_ACK))
    else $error("data byte not reported");
  a_dir_sets_mode: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (state_r == SM_M_ACK && adv_w && q_r == 2'h3 && first_r) |=>
    mode_r == ($past(shreg_r[0]) ? MODE_MRX : MODE_MTX)) else $error("direction bit misread");
  a_status_timing: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    $rose(flag_r) |=> status_r == code_r ##1 (!$past(flag_r) || status_r == code_r)) else $error("status late");
  a_status_idle_code: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    !$past(flag_r) |-> status_r == `TWOP_SC_NONE) else $error("stale status shown");
  a_stop_no_flag: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    stop_evt_r |-> !done_r ##1 !done_r ##1 !flag_r) else $error("flag raised after stop");

  c_start_sent: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    done_r && code_r == `TWOP_SC_START);
  c_data_sent: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    done_r && code_r == `TWOP_SC_MTD_ACK);
  c_slave_addressed: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    done_r && code_r == `TWOP_SC_SW_ADDR);
  c_stop_sent: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n) stop_evt_r);

endmodule // twop_ctrl

// *** rtl/twop_params.svh ***
// constants of the two-wire operation handshake controller
`ifndef TWOP_PARAMS_SVH
`define TWOP_PARAMS_SVH

// ==========================================================
// register map (byte addresses, one word each)
`define TWOP_ADR_W 5
`define TWOP_OFS_CTRL 5'h00
`define TWOP_OFS_STATUS 5'h04
`define TWOP_OFS_DATA 5'h08
`define TWOP_OFS_IRQ_ST 5'h0C
`define TWOP_OFS_IRQ_MASK 5'h10

// ==========================================================
// bus_ctrl_reg fields
`define TWOP_CTRL_FLAG 7
`define TWOP_CTRL_ACKEN 6
`define TWOP_CTRL_START 5
`define TWOP_CTRL_STOP 4
`define TWOP_CTRL_WC 3
`define TWOP_CTRL_EN 2
`define TWOP_CTRL_MODE_LSB 8
`define TWOP_CTRL_RST 8'h00

// ==========================================================
// interrupt status / mask fields
`define TWOP_IRQ_W 3
`define TWOP_IRQ_DONE 0
`define TWOP_IRQ_STOP 1
`define TWOP_IRQ_WC 2

// ==========================================================
// bus_state_code_reg codes (low three bits always zero)
`define TWOP_SC_NONE 8'hF8
`define TWOP_SC_START 8'h08
`define TWOP_SC_RSTART 8'h10
`define TWOP_SC_MW_ACK 8'h18
`define TWOP_SC_MW_NACK 8'h20
`define TWOP_SC_MTD_ACK 8'h28
`define TWOP_SC_MTD_NACK 8'h30
`define TWOP_SC_MR_ACK 8'h40
`define TWOP_SC_MR_NACK 8'h48
`define TWOP_SC_MRD_ACK 8'h50
`define TWOP_SC_MRD_NACK 8'h58
`define TWOP_SC_SW_ADDR 8'h60
`define TWOP_SC_SRD_ACK 8'h80
`define TWOP_SC_SRD_NACK 8'h88
`define TWOP_SC_SR_ADDR 8'hA8
`define TWOP_SC_STD_ACK 8'hB8
`define TWOP_SC_STD_NACK 8'hC0

// ==========================================================
// timing: system clock period and serial bit time in ns
`define TWOP_CLK_NS 40
`define TWOP_BIT_NS 10000
`define TWOP_QTR_CYC ((`TWOP_BIT_NS / 4) / `TWOP_CLK_NS)
`define TWOP_QCNT_W 7
`define TWOP_BYTE_BITS 4'h8

`endif

// *** rtl/twop_pkg.sv ***
// types of the two-wire operation handshake controller
package twop_pkg;
  // ==========================================================
  // engine states
  typedef enum logic [3:0] {
    SM_IDLE, SM_M_START, SM_M_BIT, SM_M_ACK, SM_M_STOP, SM_HOLD,
    SM_S_RX, SM_S_RACK, SM_S_TX, SM_S_TACK
  } twop_state_e;
  // ==========================================================
  // transfer modes
  typedef enum logic [2:0] {
    MODE_NONE, MODE_MTX, MODE_MRX, MODE_STX, MODE_SRX
  } twop_mode_e;
endpackage

// *** verif/twop_far_slave.sv ***
// behavioural far-side slave device for the two-wire controller bench
`timescale 1ns/1ps

module twop_far_slave #(
  parameter logic [6:0] DEV_ADDR = 7'h2A,
  parameter int STRETCH_NS = 9000
) (
  // bus line levels, pulled up
  input wire logic i_scl,
  input wire logic i_sda,
  // behaviour chosen by the bench
  input wire logic i_nack,
  input wire logic i_stretch,
  input wire logic [7:0] i_tx_byte,
  // open-drain drivers and last byte seen
  output logic o_scl_oe,
  output logic o_sda_oe,
  output logic [7:0] o_rx_byte
);
  // ==========================================================
  // byte tracking: k is the bit of the byte, 8 the ack slot
  logic [7:0] sh_r = 8'h00;
  logic act = 1'b0, fresh = 1'b0, first = 1'b0, rd = 1'b0, mine = 1'b0;
  int k = 0;

  initial begin
    o_scl_oe = 1'b0;
    o_sda_oe = 1'b0;
    o_rx_byte = 8'h00;
  end

  // start and stop are data edges while the clock is high
  always @(negedge i_sda) begin
    if (i_scl === 1'b1) begin
      act = 1'b1;
      fresh = 1'b1;
      mine = 1'b1;
    end
  end
  always @(posedge i_sda) begin
    if (i_scl === 1'b1) begin
      act = 1'b0;
      o_sda_oe = 1'b0;
    end
  end

  // sample on the rising clock; a high ack from the master ends our sending
  always @(posedge i_scl) begin
    if (act && k < 8) begin
      sh_r = {sh_r[6:0], i_sda};
    end
    if (act && k == 8 && rd && !first && i_sda) begin
      mine = 1'b0;
    end
  end

  // drive on the falling clock; a released line floats high through the pull-up
  always @(negedge i_scl) begin
    if (act) begin
      if (fresh || k == 8) begin
        first = fresh;
        k = 0;
      end else begin
        k = k + 1;
      end
      fresh = 1'b0;
      if (k == 8 && first) begin
        rd = sh_r[0];
        mine = (sh_r[7:1] == DEV_ADDR);
      end
      if (k == 8) begin
        o_rx_byte = sh_r;
        o_sda_oe = mine && !(rd && !first) && !(i_nack && !first);
      end else begin
        o_sda_oe = mine && rd && !first && !i_tx_byte[7 - k];
      end
      // slow answer: hold the clock low before the ack bit
      if (k == 8 && mine && i_stretch) begin
        o_scl_oe = 1'b1;
        #(STRETCH_NS) o_scl_oe = 1'b0;
      end
    end
  end
endmodule // twop_far_slave

// *** verif/tb_twop_ctrl.sv ***
// self-checking bench for the two-wire operation handshake controller
`timescale 1ns/1ps
`include "twop_params.svh"

module tb_twop_ctrl;
  import twop_pkg::*;
  // ==========================================================
  // signals; the wires resolve every open-drain driver with a pull-up
  localparam logic [6:0] SLV_ADDR = 7'h2A;
  localparam logic [7:0] SELF_ADDR = 8'hA2;
  logic i_clk_sys, i_reset_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, o_wb_ack, o_irq;
  logic [`TWOP_ADR_W-1:0] adr = '0;
  logic [31:0] wdat = '0, o_wb_dat, rq, ctl_seen;
  logic scl_oe, sda_oe, slv_scl_oe, slv_sda_oe, ext_scl_oe = 1'b0, ext_sda_oe = 1'b0;
  logic nack = 1'b0, stretch = 1'b0, scl_lvl, sda_lvl;
  logic [7:0] tx_byte = 8'h00, rx_byte;
  twop_mode_e mode;
  int mismatches = 0, tests_run = 0;
  wire scl_w = !(scl_oe | slv_scl_oe | ext_scl_oe);
  wire sda_w = !(sda_oe | slv_sda_oe | ext_sda_oe);

  twop_ctrl u_dut (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_scl(scl_w),
    .o_scl_o(scl_lvl), .o_scl_oe(scl_oe), .i_sda(sda_w), .o_sda_o(sda_lvl), .o_sda_oe(sda_oe), .o_bus_mode(mode),
    .o_irq(o_irq));
  twop_far_slave #(.DEV_ADDR(SLV_ADDR)) u_slave (.i_scl(scl_w), .i_sda(sda_w), .i_nack(nack), .i_stretch(stretch),
    .i_tx_byte(tx_byte), .o_scl_oe(slv_scl_oe), .o_sda_oe(slv_sda_oe), .o_rx_byte(rx_byte));

  // 25 MHz system clock
  initial begin
    i_clk_sys = 1'b0;
    forever #20 i_clk_sys = ~i_clk_sys;
  end

  // ==========================================================
  // comparison, bus cycle and software step tasks
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // classic cycle: request held until ack is sampled high
  task automatic wb(input logic w, input logic [`TWOP_ADR_W-1:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge i_clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge i_clk_sys);
      t++;
    end while (o_wb_ack !== 1'b1 && t < 50);
    if (o_wb_ack !== 1'b1) mismatches++;
    rq = o_wb_dat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic rdchk(input string what, input logic [`TWOP_ADR_W-1:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(what, rq, exp);
  endtask
  // launch (a zero control value launches nothing), wait for the interrupt, check and clear
  task automatic op(input logic [7:0] c, input logic [7:0] code, input logic [2:0] ist);
    int t;
    t = 0;
    if (c !== 8'h00) wb(1'b1, `TWOP_OFS_CTRL, {24'h000000, c});
    while (o_irq !== 1'b1 && t < 6000) begin
      @(posedge i_clk_sys);
      t++;
    end
    if (o_irq !== 1'b1) mismatches++;
    repeat (4) @(posedge i_clk_sys);
    wb(1'b0, `TWOP_OFS_CTRL, 32'h0);
    ctl_seen = rq;
    chk("flag", rq[7], ist[0]);
    chk("scl_level", scl_w, !ist[0]);
    chk("line_levels", {scl_lvl, sda_lvl}, 2'b00);
    rdchk("status", `TWOP_OFS_STATUS, {24'h000000, code});
    chk("status_masked", rq[7:0] & 8'hF8, code);
    rdchk("irq_status", `TWOP_OFS_IRQ_ST, {29'h0, ist});
    wb(1'b1, `TWOP_OFS_IRQ_ST, 32'h7);
    repeat (2) @(posedge i_clk_sys);
    chk("irq_cleared", o_irq, 1'b0);
  endtask
  // half period of a foreign master's 320 ns clock; data moves mid-low
  task automatic ext_half(input logic s, input logic d);
    ext_scl_oe = !s;
    #80;
    ext_sda_oe = !d;
    #80;
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // watchdog, well beyond the roughly 16000 cycles the tests take
  initial begin
    repeat (80000) @(posedge i_clk_sys);
    mismatches++;
    end_of_test();
  end

  // ==========================================================
  // test sequence
  initial begin
    repeat (10) @(posedge i_clk_sys);
    i_reset_n <= 1'b1;
    rdchk("status_idle", `TWOP_OFS_STATUS, 32'hF8);
    rdchk("ctrl_reset", `TWOP_OFS_CTRL, 32'h0);
    rdchk("unmapped", 5'h14, 32'h0);
    wb(1'b1, `TWOP_OFS_IRQ_MASK, 32'h3);
    rdchk("irq_mask", `TWOP_OFS_IRQ_MASK, 32'h3);
    $display("test registers done");
    // master transmit: start, address, data with a write collision, refused data, restart, stop
    op(8'hA4, `TWOP_SC_START, 3'b001);
    wb(1'b1, `TWOP_OFS_DATA, {24'h000000, SLV_ADDR, 1'b0});
    op(8'h84, `TWOP_SC_MW_ACK, 3'b001);
    chk("addr_write_dir", rx_byte, {SLV_ADDR, 1'b0});
    chk("mode_mtx", mode, MODE_MTX);
    wb(1'b1, `TWOP_OFS_DATA, 32'hA5);
    wb(1'b1, `TWOP_OFS_CTRL, 32'h84);
    wb(1'b1, `TWOP_OFS_DATA, 32'h3C);
    repeat (2) @(posedge i_clk_sys);
    chk("irq_masked", o_irq, 1'b0);
    op(8'h00, `TWOP_SC_MTD_ACK, 3'b101);
    chk("collision_bit", ctl_seen[3], 1'b1);
    chk("sent_byte", rx_byte, 8'hA5);
    rdchk("data_kept", `TWOP_OFS_DATA, 32'hA5);
    nack <= 1'b1;
    wb(1'b1, `TWOP_OFS_DATA, 32'h5A);
    op(8'h84, `TWOP_SC_MTD_NACK, 3'b001);
    nack <= 1'b0;
    op(8'hA4, `TWOP_SC_RSTART, 3'b001);
    op(8'h94, `TWOP_SC_NONE, 3'b010);
    chk("sda_free", sda_w, 1'b1);
    $display("test master transmit done");
    // master receive with a slow address answer, acked then refused byte
    tx_byte <= 8'hC3;
    stretch <= 1'b1;
    op(8'hA4, `TWOP_SC_START, 3'b001);
    wb(1'b1, `TWOP_OFS_DATA, {24'h000000, SLV_ADDR, 1'b1});
    op(8'h84, `TWOP_SC_MR_ACK, 3'b001);
    stretch <= 1'b0;
    chk("mode_mrx", mode, MODE_MRX);
    op(8'hC4, `TWOP_SC_MRD_ACK, 3'b001);
    rdchk("rx_first", `TWOP_OFS_DATA, 32'hC3);
    tx_byte <= 8'h81;
    op(8'h84, `TWOP_SC_MRD_NACK, 3'b001);
    rdchk("rx_last", `TWOP_OFS_DATA, 32'h81);
    op(8'h94, `TWOP_SC_NONE, 3'b010);
    $display("test master receive done");
    // slave receive then slave transmit: a foreign master addresses us, we ack and stretch
    for (int r = 0; r < 2; r++) begin
      wb(1'b1, `TWOP_OFS_CTRL, 32'h44);
      #13;
      ext_half(1'b1, 1'b1);
      ext_half(1'b1, 1'b0);
      for (int i = 7; i >= 0; i--) begin
        ext_half(1'b0, (i == 0) ? r[0] : SELF_ADDR[i]);
        ext_half(1'b1, (i == 0) ? r[0] : SELF_ADDR[i]);
      end
      ext_half(1'b0, 1'b1);
      ext_half(1'b1, 1'b1);
      chk("slave_ack", sda_w, 1'b0);
      ext_half(1'b0, 1'b0);
      ext_scl_oe = 1'b0;
      op(8'h00, r[0] ? `TWOP_SC_SR_ADDR : `TWOP_SC_SW_ADDR, 3'b001);
      chk("slave_mode", mode, r[0] ? MODE_STX : MODE_SRX);
      wb(1'b1, `TWOP_OFS_CTRL, 32'hC4);
      for (int t = 0; t < 100 && scl_w !== 1'b1; t++) #40;
      chk("scl_released", scl_w, 1'b1);
      #160;
      ext_sda_oe = 1'b0;
      #800;
      chk("mode_idle", mode, MODE_NONE);
    end
    $display("test slave modes done");
    end_of_test();
  end
endmodule // tb_twop_ctrl
